/* hdl/ssd_defs.svh */
`ifndef SSD_DEFS_SVH
`define SSD_DEFS_SVH

// Clock and sync period
`define SSD_CLK_MHZ 125
`define SSD_SYNC_PERIOD_US 500

// Serial messaging channel
`define SSD_SER_FRAMES 5'h12
`define SSD_CRC_FIRST_FRAME 5'h07
`define SSD_CRC_BITS 5'h06
`define SSD_CRC_LEN 6
`define SSD_CRC_INIT 6'h15
`define SSD_CRC_POLY 6'h19
`define SSD_CRC_ZEROS 6'h00
`define SSD_SER_BITS 24
`define SSD_FMT_POS 3

// Downlink frames
`define SSD_START_ZEROS 6'h05
`define SSD_START_ONES 6'h1F
`define SSD_RUN_MAX 6'h3F
`define SSD_POS_ZSTART 6'h02
`define SSD_POS_OSTART 6'h01
`define SSD_POS_LAST_START 6'h03
`define SSD_POS_BODY 6'h04
`define SSD_LEN_SHORT 6'h0F
`define SSD_LEN_LONG 6'h1D
`define SSD_LEN_XLONG 6'h25
`define SSD_DL_BITS 25
`define SSD_HDR_LAST 5'h05
`define SSD_ADDR_GLOBAL 3'h0
`define SSD_FC_LONG 3'h4
`define SSD_FC_XLONG 3'h6
`define SSD_RESP_PERIODS 2'h2

// Register offsets
`define SSD_OFS_CTRL 8'h00
`define SSD_OFS_SER_DATA 8'h04
`define SSD_OFS_SER_STAT 8'h08
`define SSD_OFS_DL_STAT 8'h0C
`define SSD_OFS_DL_DATA 8'h10
`define SSD_OFS_DEV_ADDR 8'h14

`endif

/* hdl/ssd_pkg.sv */
package ssd_pkg;

    typedef enum logic [2:0] {
        SER_IDLE = 3'b001,
        SER_CALC = 3'b010,
        SER_RUN = 3'b100
    } ssd_ser_state_e;

    typedef enum logic [1:0] {
        DL_HUNT = 2'b01,
        DL_FRAME = 2'b10
    } ssd_dl_state_e;

    typedef struct packed {
        logic resp_en;
        logic pw_mode;
        logic fmt;
        logic ser_en;
    } ssd_ctrl_s;

    typedef struct packed {
        logic for_me;
        logic err;
        logic valid;
    } ssd_dl_stat_s;

endpackage : ssd_pkg

/* hdl/ssd_crc6.sv */
`timescale 1ns/1ns
`include "ssd_defs.svh"
module ssd_crc6
    import ssd_pkg::*;
#(
    parameter int NBITS = `SSD_SER_BITS
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Request
    input wire logic start,
    input wire logic [NBITS-1:0] msg,
    // Result
    output logic busy,
    output logic [5:0] crc
);
    localparam int TOTAL = NBITS + `SSD_CRC_LEN;
    localparam int CW = $clog2(TOTAL + 1);

    logic [TOTAL-1:0] shift_reg;
    logic [CW-1:0] cnt_reg;
    logic [5:0] crc_reg;

    assign busy = cnt_reg != '0;
    assign crc = crc_reg;

    // Bit 0 of msg enters first; zeros trail the message
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shift_reg <= '0;
            cnt_reg <= '0;
            crc_reg <= `SSD_CRC_INIT;
        end
        else if (start)
        begin
            shift_reg <= {`SSD_CRC_ZEROS, msg};
            cnt_reg <= CW'(TOTAL);
            crc_reg <= `SSD_CRC_INIT;
        end
        else if (busy)
        begin
            shift_reg <= shift_reg >> 1;
            cnt_reg <= cnt_reg - CW'(1);
            crc_reg <= {crc_reg[4:0], shift_reg[0]}
                ^ (crc_reg[5] ? `SSD_CRC_POLY : 6'h00);
        end
    end

    a_crc_init: assert property (@(posedge pclk) disable iff (!presetn)
        start |=> crc_reg == `SSD_CRC_INIT)
        else $error("crc register not seeded");
    a_crc_span: assert property (@(posedge pclk) disable iff (!presetn)
        start |=> busy [*8] ##22 busy ##1 !busy)
        else $error("crc shift length wrong");

endmodule : ssd_crc6

/* hdl/ssd_sensor_link.sv */
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`include "ssd_defs.svh"
// Functional notes
// - Serial message spans 18 frames, two bits each
// - Frame 8 second bit selects serial format
// - Messaging bits go in their frame's slot
// - Six-bit CRC, 1+x3+x4+x6, seed 010101
// - CRC input frames 7 to 18, first first
// - Six zeros appended; register holds checksum
// - Checksum sent top bit first
// - Tooth gap: pulse is one, gap zero
// - Pulse width: long pulse one, short zero
// - Tooth gap formats 1-3 only, never mixed
// - Frame: start bits, address/function/data, CRC
// - Optional response within two sync periods
// - Acknowledge optional, response only on request
// - Start is five zeros or 31 ones
// - Sync one every fourth bit, stripped
// - Normal data continues during downlink traffic
// - Frame length from address and function code
module ssd_sensor_link
    import ssd_pkg::*;
#(
    parameter int SYNC_PERIOD_CYC = `SSD_SYNC_PERIOD_US * `SSD_CLK_MHZ,
    parameter int LONG_PULSE_CYC = 1000
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Supply line sync comparator
    input wire logic sync_pin,
    // Sensor data frame encoder
    input wire logic slot_go,
    output logic first_messaging_bit,
    output logic second_messaging_bit,
    output logic dl_frame_done,
    output logic resp_active
);
    localparam int HALF_CYC = SYNC_PERIOD_CYC / 2;
    localparam int MISS_CYC = SYNC_PERIOD_CYC + HALF_CYC;
    localparam int TCW = $clog2(MISS_CYC + 1);

    ssd_ctrl_s ctrl_reg;
    ssd_dl_stat_s dl_stat_reg;
    ssd_ser_state_e ser_state_reg;
    ssd_dl_state_e dl_state_reg;
    logic [`SSD_SER_BITS-1:0] ser_data_reg;
    logic [`SSD_SER_BITS-1:0] content_reg;
    logic [`SSD_DL_BITS-1:0] dl_data_reg;
    logic [`SSD_DL_BITS-1:0] dl_shift_reg;
    logic [`SSD_DL_BITS-1:0] dat_next;
    logic [2:0] dev_addr_reg;
    logic [31:0] prdata_reg;
    logic [31:0] rd_val;
    logic rd_hit;
    logic pready_reg;
    logic pslverr_reg;
    logic wr_acc;
    logic sync_meta_reg;
    logic sync_sync_reg;
    logic sync_prev_reg;
    logic sync_rise;
    logic sync_fall;
    logic [TCW-1:0] gap_reg;
    logic [TCW-1:0] width_reg;
    logic bit_stb_next;
    logic bit_val_next;
    logic dbit_stb_reg;
    logic dbit_val_reg;
    logic [5:0] zrun_reg;
    logic [5:0] orun_reg;
    logic [5:0] pos_reg;
    logic [5:0] pos_next;
    logic [5:0] len_reg;
    logic [4:0] dcnt_reg;
    logic [2:0] dl_adr_reg;
    logic [4:0] idx_reg;
    logic [4:0] idx_next;
    logic [1:0] msg_bits_reg;
    logic [1:0] resp_cnt_reg;
    logic [1:0] resp_cnt_next;
    logic resp_active_reg;
    logic dl_done;
    logic dl_abort;
    logic dl_done_reg;
    logic crc_start_reg;
    logic crc_busy;
    logic [5:0] crc_val;

    function automatic logic bad_bit(input logic [5:0] pos, input logic v);
        if (pos[1:0] == 2'h0)
            bad_bit = !v;
        else if (pos == `SSD_POS_ZSTART)
            bad_bit = !v;
        else
            bad_bit = (pos == `SSD_POS_LAST_START) && v;
    endfunction : bad_bit

    function automatic logic [5:0] frame_len(input logic [2:0] adr,
                                             input logic [2:0] fc);
        if (adr == `SSD_ADDR_GLOBAL || fc < `SSD_FC_LONG)
            frame_len = `SSD_LEN_SHORT;
        else if (fc < `SSD_FC_XLONG)
            frame_len = `SSD_LEN_LONG;
        else
            frame_len = `SSD_LEN_XLONG;
    endfunction : frame_len

    function automatic logic [1:0] msg_bits(input logic [4:0] idx,
        input logic [`SSD_SER_BITS-1:0] cont, input logic [5:0] crc);
        logic [4:0] k;
        k = 5'h00;
        if (idx < `SSD_CRC_FIRST_FRAME)
            msg_bits = {1'b1, crc[3'(`SSD_CRC_BITS - idx)]};
        else
        begin
            k = 5'((idx - `SSD_CRC_FIRST_FRAME) << 1);
            msg_bits = {cont[k + 5'h01], cont[k]};
        end
    endfunction : msg_bits

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign first_messaging_bit = msg_bits_reg[0];
    assign second_messaging_bit = msg_bits_reg[1];
    assign dl_frame_done = dl_done_reg;
    assign resp_active = resp_active_reg;

    // Zero wait state: answer prepared in the setup cycle
    assign wr_acc = psel && penable && pready_reg && pwrite;

    always_comb
    begin
        rd_hit = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (paddr)
            `SSD_OFS_CTRL: rd_val = 32'(ctrl_reg);
            `SSD_OFS_SER_DATA: rd_val = 32'(ser_data_reg);
            `SSD_OFS_SER_STAT: rd_val = 32'({crc_val, idx_reg});
            `SSD_OFS_DL_STAT: rd_val = 32'(dl_stat_reg);
            `SSD_OFS_DL_DATA: rd_val = 32'(dl_data_reg);
            `SSD_OFS_DEV_ADDR: rd_val = 32'(dev_addr_reg);
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
        else
        begin
            pready_reg <= psel && !penable;
            if (psel && !penable)
            begin
                pslverr_reg <= !rd_hit;
                prdata_reg <= pwrite ? 32'h0000_0000 : rd_val;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= '0;
            ser_data_reg <= '0;
            dev_addr_reg <= 3'h0;
        end
        else if (wr_acc)
        begin
            if (paddr == `SSD_OFS_CTRL)
                ctrl_reg <= ssd_ctrl_s'(pwdata[$bits(ssd_ctrl_s)-1:0]);
            if (paddr == `SSD_OFS_SER_DATA)
                ser_data_reg <= pwdata[`SSD_SER_BITS-1:0];
            if (paddr == `SSD_OFS_DEV_ADDR)
                dev_addr_reg <= pwdata[2:0];
        end
    end

    // Serial channel; slot_go is never held off by downlink traffic
    assign idx_next = idx_reg + 5'h01;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ser_state_reg <= SER_IDLE;
            idx_reg <= 5'h00;
            content_reg <= '0;
            crc_start_reg <= 1'b0;
            msg_bits_reg <= 2'h0;
        end
        else
        begin
            crc_start_reg <= 1'b0;
            if (slot_go)
                msg_bits_reg <= 2'h0;
            unique case (ser_state_reg)
                SER_IDLE:
                begin
                    idx_reg <= 5'h00;
                    if (ctrl_reg.ser_en)
                    begin
                        content_reg <= ser_data_reg;
                        content_reg[`SSD_FMT_POS] <= ctrl_reg.fmt;
                        crc_start_reg <= 1'b1;
                        ser_state_reg <= SER_CALC;
                    end
                end
                SER_CALC:
                begin
                    if (!crc_start_reg && !crc_busy)
                        ser_state_reg <= SER_RUN;
                end
                SER_RUN:
                begin
                    if (slot_go)
                    begin
                        idx_reg <= idx_next;
                        msg_bits_reg <= msg_bits(idx_next, content_reg,
                                                 crc_val);
                        if (idx_next == `SSD_SER_FRAMES)
                            ser_state_reg <= SER_IDLE;
                    end
                end
            endcase
        end
    end

    // Checksum prepared long before frame 1 leaves
    ssd_crc6 #(
        .NBITS(`SSD_SER_BITS)
    ) u_crc (
        .pclk(pclk),
        .presetn(presetn),
        .start(crc_start_reg),
        .msg(content_reg),
        .busy(crc_busy),
        .crc(crc_val)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_meta_reg <= 1'b0;
            sync_sync_reg <= 1'b0;
            sync_prev_reg <= 1'b0;
        end
        else
        begin
            sync_meta_reg <= sync_pin;
            sync_sync_reg <= sync_meta_reg;
            sync_prev_reg <= sync_sync_reg;
        end
    end

    assign sync_rise = sync_sync_reg && !sync_prev_reg;
    assign sync_fall = !sync_sync_reg && sync_prev_reg;

    // Gap window assumes a fixed sync period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gap_reg <= '0;
        else if (sync_rise)
            gap_reg <= '0;
        else if (gap_reg == TCW'(MISS_CYC))
            gap_reg <= TCW'(HALF_CYC);
        else
            gap_reg <= gap_reg + TCW'(1);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            width_reg <= '0;
        else if (sync_rise)
            width_reg <= '0;
        else if (sync_sync_reg && width_reg != '1)
            width_reg <= width_reg + TCW'(1);
    end

    always_comb
    begin
        bit_stb_next = 1'b0;
        bit_val_next = 1'b0;
        if (ctrl_reg.pw_mode)
        begin
            bit_stb_next = sync_fall;
            bit_val_next = width_reg >= TCW'(LONG_PULSE_CYC);
        end
        else if (sync_rise)
        begin
            bit_stb_next = 1'b1;
            bit_val_next = 1'b1;
        end
        else if (gap_reg == TCW'(MISS_CYC))
            bit_stb_next = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dbit_stb_reg <= 1'b0;
            dbit_val_reg <= 1'b0;
        end
        else
        begin
            dbit_stb_reg <= bit_stb_next;
            dbit_val_reg <= bit_val_next;
        end
    end

    // Run lengths watched in every state, so a lost frame resyncs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            zrun_reg <= 6'h00;
            orun_reg <= 6'h00;
        end
        else if (dbit_stb_reg)
        begin
            if (dbit_val_reg)
            begin
                zrun_reg <= 6'h00;
                if (orun_reg != `SSD_RUN_MAX)
                    orun_reg <= orun_reg + 6'h01;
            end
            else
            begin
                orun_reg <= 6'h00;
                if (zrun_reg != `SSD_RUN_MAX)
                    zrun_reg <= zrun_reg + 6'h01;
            end
        end
    end

    assign pos_next = pos_reg + 6'h01;
    assign dat_next = {dl_shift_reg[`SSD_DL_BITS-2:0], dbit_val_reg};
    assign dl_abort = dbit_stb_reg && dl_state_reg == DL_FRAME
        && bad_bit(pos_next, dbit_val_reg);
    assign dl_done = dbit_stb_reg && dl_state_reg == DL_FRAME
        && !bad_bit(pos_next, dbit_val_reg) && pos_next == len_reg;

    // Formats 1-3 are assembled only under tooth gap coding
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dl_state_reg <= DL_HUNT;
            pos_reg <= 6'h00;
            dcnt_reg <= 5'h00;
            len_reg <= `SSD_LEN_XLONG;
            dl_shift_reg <= '0;
            dl_adr_reg <= 3'h0;
        end
        else if (ctrl_reg.pw_mode)
            dl_state_reg <= DL_HUNT;
        else if (dbit_stb_reg)
        begin
            unique case (dl_state_reg)
                DL_HUNT:
                begin
                    dcnt_reg <= 5'h00;
                    len_reg <= `SSD_LEN_XLONG;
                    // Bits of a dropped frame must not leak into the next
                    dl_shift_reg <= '0;
                    if (dbit_val_reg && zrun_reg >= `SSD_START_ZEROS)
                    begin
                        dl_state_reg <= DL_FRAME;
                        pos_reg <= `SSD_POS_ZSTART;
                    end
                    else if (!dbit_val_reg && orun_reg >= `SSD_START_ONES)
                    begin
                        dl_state_reg <= DL_FRAME;
                        pos_reg <= `SSD_POS_OSTART;
                    end
                end
                DL_FRAME:
                begin
                    pos_reg <= pos_next;
                    if (bad_bit(pos_next, dbit_val_reg) || dl_done)
                        dl_state_reg <= DL_HUNT;
                    else if (pos_next > `SSD_POS_BODY
                             && pos_next[1:0] != 2'h0)
                    begin
                        dl_shift_reg <= dat_next;
                        dcnt_reg <= dcnt_reg + 5'h01;
                        if (dcnt_reg == `SSD_HDR_LAST)
                        begin
                            // Address sits at the head, not at a fixed bit
                            dl_adr_reg <= dat_next[5:3];
                            len_reg <= frame_len(dat_next[5:3],
                                                 dat_next[2:0]);
                        end
                    end
                end
            endcase
        end
    end

    // Hardware set wins over software clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dl_stat_reg <= '0;
            dl_data_reg <= '0;
            dl_done_reg <= 1'b0;
        end
        else
        begin
            dl_done_reg <= dl_done;
            if (dl_done)
            begin
                dl_data_reg <= dat_next;
                dl_stat_reg.for_me <= dl_adr_reg == dev_addr_reg;
            end
            dl_stat_reg.valid <= dl_done || (dl_stat_reg.valid
                && !(wr_acc && paddr == `SSD_OFS_DL_STAT
                     && pwdata[0]));
            dl_stat_reg.err <= dl_abort || (dl_stat_reg.err
                && !(wr_acc && paddr == `SSD_OFS_DL_STAT
                     && pwdata[1]));
        end
    end

    // Response only when software asks for it
    always_comb
    begin
        resp_cnt_next = resp_cnt_reg;
        if (dl_done && ctrl_reg.resp_en
            && dl_adr_reg == dev_addr_reg)
            resp_cnt_next = `SSD_RESP_PERIODS;
        else if (sync_rise && resp_cnt_reg != 2'h0)
            resp_cnt_next = resp_cnt_reg - 2'h1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            resp_cnt_reg <= 2'h0;
            resp_active_reg <= 1'b0;
        end
        else
        begin
            resp_cnt_reg <= resp_cnt_next;
            resp_active_reg <= resp_cnt_next != 2'h0;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_msg_wrap: assert property (
        ser_state_reg == SER_RUN && slot_go && idx_reg == 5'h11
        |=> idx_reg == `SSD_SER_FRAMES && ser_state_reg == SER_IDLE)
        else $error("serial message not 18 frames");
    a_fmt_frame8: assert property (
        ser_state_reg == SER_RUN && slot_go && idx_reg == 5'h07
        |=> second_messaging_bit == content_reg[`SSD_FMT_POS])
        else $error("format bit not in frame 8");
    a_crc_msb: assert property (
        ser_state_reg == SER_RUN && slot_go && idx_reg == 5'h00
        |=> first_messaging_bit == crc_val[5])
        else $error("checksum not msb first");
    a_slot_kept: assert property (
        ser_state_reg == SER_RUN && slot_go && dl_state_reg == DL_FRAME
        |=> idx_reg == $past(idx_reg) + 5'h01)
        else $error("serial slot lost in downlink");
    a_tooth_one: assert property (
        !ctrl_reg.pw_mode && sync_rise |=> dbit_stb_reg && dbit_val_reg)
        else $error("sync pulse not decoded as one");
    a_pw_long: assert property (
        ctrl_reg.pw_mode && sync_fall
        && width_reg >= TCW'(LONG_PULSE_CYC)
        |=> dbit_stb_reg && dbit_val_reg)
        else $error("long pulse not decoded as one");
    a_pw_noframe: assert property (
        ctrl_reg.pw_mode |=> dl_state_reg == DL_HUNT)
        else $error("frame assembled in pulse width mode");
    a_sync_strip: assert property (
        dl_abort |=> dl_state_reg == DL_HUNT && dl_stat_reg.err)
        else $error("bad sync bit not rejected");
    a_resp_window: assert property (
        dl_done && ctrl_reg.resp_en && dl_adr_reg == dev_addr_reg
        |=> resp_active_reg && resp_cnt_reg == `SSD_RESP_PERIODS)
        else $error("response window not opened");

    c_msg_done: cover property (ser_state_reg == SER_RUN && slot_go
        && idx_reg == 5'h11);
    c_dl_frame: cover property (dl_done);
    c_pw_one: cover property (ctrl_reg.pw_mode && bit_stb_next
        && bit_val_next);
    c_start_ones: cover property (dl_state_reg == DL_HUNT && dbit_stb_reg
        && !dbit_val_reg && orun_reg >= `SSD_START_ONES);

endmodule : ssd_sensor_link

/* tb/ssd_ecu_model.sv */
`timescale 1ns/1ns
// One sync slot per period; a missing pulse is a zero
module ssd_ecu_model
#(
    parameter int PERIOD = 64,
    parameter int WIDTH = 4
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Frame request, first bit at the top
    input wire logic go,
    input wire logic [31:0] bits,
    input wire logic [5:0] nbits,
    // Supply line
    output logic sync_pin
);
    int cnt_reg;
    logic [5:0] idx_reg;
    logic cur_reg;
    // Fixed period, so gaps stay readable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg <= 0;
            idx_reg <= 6'h00;
            cur_reg <= 1'b1;
            sync_pin <= 1'b0;
        end
        else
        begin
            cnt_reg <= (cnt_reg == PERIOD - 1) ? 0 : cnt_reg + 1;
            sync_pin <= cur_reg && (cnt_reg < WIDTH);
            if (go)
                idx_reg <= nbits;
            else if (cnt_reg == PERIOD - 1 && idx_reg != 6'h00)
                idx_reg <= idx_reg - 6'h01;
            // Idle periods carry plain ones
            if (cnt_reg == PERIOD - 1)
                cur_reg <= (idx_reg != 6'h00) ? bits[idx_reg - 6'h01] : 1'b1;
        end
    end
endmodule : ssd_ecu_model

/* tb/ssd_tb.sv */
`timescale 1ns/1ns
`include "ssd_defs.svh"
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, bits;
    logic sync_pin, slot_go, go, e, dl_frame_done, resp_active;
    logic first_messaging_bit, second_messaging_bit;
    logic [5:0] nbits, crc;
    logic [23:0] c;
    int err_total, tests_run, cyc;

    ssd_sensor_link #(.SYNC_PERIOD_CYC(64), .LONG_PULSE_CYC(8)) u_ssd_sensor_link
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sync_pin(sync_pin),
        .slot_go(slot_go), .first_messaging_bit(first_messaging_bit),
        .second_messaging_bit(second_messaging_bit),
        .dl_frame_done(dl_frame_done), .resp_active(resp_active)
    );
    ssd_ecu_model u_ssd_ecu_model
    (
        .pclk(pclk), .presetn(presetn), .go(go), .bits(bits),
        .nbits(nbits), .sync_pin(sync_pin)
    );

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            $display("[FAIL] %0t timeout", $time);
            err_total++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, exp, input string m);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t %s got %h", $time, m, got);
        end
    endtask : chk

    // Holds the request until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input logic xe);
        apb(1'b0, a, 32'h00000000);
        chk(q, x, "read data");
        chk(e, xe, "slave error");
    endtask : rd

    task automatic frame(input logic [1:0] x);
        @(posedge pclk);
        slot_go <= 1'b1;
        @(posedge pclk);
        slot_go <= 1'b0;
        @(posedge pclk);
        chk({first_messaging_bit, second_messaging_bit}, x, "msg bits");
    endtask : frame

    // Seed 010101, 1+x3+x4+x6, six zeros appended
    function automatic logic [5:0] crc6(input logic [23:0] d);
        logic [5:0] r;
        logic top;
        r = 6'h15;
        for (int i = 0; i < 30; i++)
        begin
            top = r[5];
            r = {r[4:0], (i < 24) ? d[i] : 1'b0};
            if (top)
                r = r ^ 6'h19;
        end
        return r;
    endfunction : crc6

    initial
    begin
        {presetn, psel, penable, pwrite, slot_go, go} = 6'h00;
        {paddr, pwdata, bits, nbits} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(`SSD_OFS_CTRL, 32'h00000000, 1'b0);
        frame(2'b00);
        $display("test reset done");
        wr_all();
        c = 24'h5A3C9E;
        crc = crc6(c);
        // Frames fall inside the downlink frame, so both run at once
        repeat (500) @(posedge pclk);
        rd(`SSD_OFS_SER_STAT, {21'h000000, crc, 5'h00}, 1'b0);
        for (int f = 1; f <= 18; f++)
            if (f <= 6)
                frame({crc[6 - f], 1'b1});
            else
                frame({c[2 * (f - 7)], c[2 * (f - 7) + 1]});
        // Engine rearms and recomputes the same checksum
        repeat (40) @(posedge pclk);
        rd(`SSD_OFS_SER_STAT, {21'h000000, crc, 5'h00}, 1'b0);
        $display("test serial done");
        do
            @(posedge pclk);
        while (dl_frame_done !== 1'b1);
        repeat (3) @(posedge pclk);
        chk(resp_active, 1'b1, "response window");
        rd(`SSD_OFS_DL_DATA, 32'h00000143, 1'b0);
        rd(`SSD_OFS_DL_STAT, 32'h00000005, 1'b0);
        $display("test downlink done");
        apb(1'b1, `SSD_OFS_CTRL, 32'h00000004);
        apb(1'b1, `SSD_OFS_DL_STAT, 32'h00000003);
        rd(`SSD_OFS_DL_STAT, 32'h00000004, 1'b0);
        @(posedge pclk);
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (1400) @(posedge pclk);
        rd(`SSD_OFS_DL_STAT, 32'h00000004, 1'b0);
        $display("test pulse width done");
        rd(8'h20, 32'h00000000, 1'b1);
        $display("test unmapped done");
        give_verdict();
    end

    // Short frame: zero run, 1 0 S, address 5, code 0, check 011
    task automatic wr_all;
        apb(1'b1, `SSD_OFS_DEV_ADDR, 32'h00000005);
        apb(1'b1, `SSD_OFS_SER_DATA, 32'h005A3C96);
        apb(1'b1, `SSD_OFS_CTRL, 32'h0000000B);
        @(posedge pclk);
        go <= 1'b1;
        bits <= 32'h00002D8B;
        nbits <= 6'h13;
        @(posedge pclk);
        go <= 1'b0;
    endtask : wr_all
endmodule : testbench
